// >>> hdl/nvw_core.sv
// Command decoder, wiper scratchpad and nonvolatile store of the
// digital potentiometer control logic.
// Assumes serial pins driven by a host and sampled on the system clock.
`include "nvw_regs.svh"

// Contract
// R1: Write protect low blocks all changes except preset and restore 1, 8.
// R2: Host sends a no-operation frame before raising write protect.
// R3: Preset strobe rising edge reloads the wiper from the store.
// R4: Store holds midscale 512 until the user first writes it.
// R5: Commands execute only when chip select rises.
// R6: Ready marks completion of commands 2, 3, 8, 9, 10 and preset.
// R7: Second general output follows bit D1 of store address 1.
// R8: A store takes 25 ms and locks the shift register meanwhile.
// R9: Ready pulses low until the store completes.
// R10: Wiper scratchpad sets the position directly; zero means terminal B.
// R11: Power-up restores the wiper from the saved store value.
// R12: Any full data word may rewrite the wiper without limit.
// R13: Sixteen commands are decoded.
// R14: Readback commands shift wiper or store data out next frame.
// R15: Frames are 24 bits, MSB first: command, address, data.
// R16: Command 0xB address 0 writes wiper; 0x2 saves it to the store.
// R17: Preset strobe low forces the wiper to midscale.
// R18: Chip select pulse without clocks repeats the previous command.
// R19: Wiper is 10 bits; steps saturate at both ends.
module nvw_core
  import nvw_pkg::*;
#(
  parameter int STORE_CYCLES = `NVW_STORE_CYCLES
) (
  // Clock and resets
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic factory_reset_n_in,
  // Serial link
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic cs_n_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Control pins
  input wire logic write_protect_n_in,
  input wire logic preset_strobe_n_in,
  // Ready, open drain
  output logic ready_out,
  output logic ready_oe_out,
  // Wiper and general outputs
  output logic [9:0] wiper_scratchpad_out,
  output logic nv_general_output_one_out,
  output logic nv_general_output_two_out
);

  localparam logic [19:0] STORE_LOAD = 20'(STORE_CYCLES - 1);

  // Pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] pin_lvl;
  logic [4:0] pin_prev_reg;
  assign pin_raw = {preset_strobe_n_in, write_protect_n_in, cs_n_in,
                    sdi_in, sclk_in};
  nvw_sync #(
    .WIDTH(5),
    .RESET_VALUE(5'h1C)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .async_in(pin_raw),
    .level_out(pin_lvl)
  );

  logic sclk_lvl;
  logic sdi_lvl;
  logic cs_lvl;
  logic wp_lvl;
  logic preset_lvl;
  logic sclk_rise;
  logic cs_rise;
  logic cs_fall;
  logic preset_rise;
  assign sclk_lvl = pin_lvl[0];
  assign sdi_lvl = pin_lvl[1];
  assign cs_lvl = pin_lvl[2];
  assign wp_lvl = pin_lvl[3];
  assign preset_lvl = pin_lvl[4];
  assign sclk_rise = sclk_lvl & ~pin_prev_reg[0];
  assign cs_rise = cs_lvl & ~pin_prev_reg[2];
  assign cs_fall = ~cs_lvl & pin_prev_reg[2];
  assign preset_rise = preset_lvl & ~pin_prev_reg[4];

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_prev_reg <= 5'h1C;
    end else begin
      pin_prev_reg <= pin_lvl;
    end
  end

  // State
  nvw_state_t state_reg;
  nvw_state_t state_next;
  logic [9:0] wiper_reg;
  logic [9:0] wiper_next;
  logic [19:0] store_cnt_reg;
  logic [3:0] pend_addr_reg;
  logic [15:0] pend_data_reg;
  logic [15:0] store_reg [`NVW_STORE_DEPTH];
  logic [23:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic any_bits_reg;
  logic [23:0] prev_word_reg;
  logic prev_valid_reg;

  // Frame decode
  logic shifting;
  logic frame_ok;
  logic use_prev;
  logic exec_valid;
  logic exec_ok;
  logic wp_block;
  logic is_read;
  logic is_store;
  logic is_report;
  logic store_we;
  logic [23:0] exec_word;
  nvw_cmd_t exec_cmd;
  logic [3:0] exec_addr;
  logic [15:0] exec_data;
  logic [15:0] read_data;
  logic [9:0] store_wiper;

  assign shifting = ~cs_lvl && (state_reg != ST_STORE); // see R8
  assign frame_ok = any_bits_reg && (bit_cnt_reg == 5'h00); // see R15
  assign use_prev = ~any_bits_reg && prev_valid_reg; // see R18
  assign exec_valid = (state_reg == ST_IDLE) && cs_rise
                      && (frame_ok || use_prev); // see R5
  assign exec_word = frame_ok ? shift_reg : prev_word_reg;
  assign exec_cmd = nvw_cmd_t'(exec_word[`NVW_CMD_MSB:`NVW_CMD_LSB]);
  assign exec_addr = exec_word[`NVW_ADDR_MSB:`NVW_ADDR_LSB];
  assign exec_data = exec_word[`NVW_DATA_MSB:`NVW_DATA_LSB];
  assign wp_block = ~wp_lvl && (exec_cmd != CMD_RESTORE)
                    && (exec_cmd != CMD_RESET_NV); // see R1
  assign exec_ok = exec_valid && ~wp_block;
  assign is_read = (exec_cmd == CMD_READ_NV)
                   || (exec_cmd == CMD_READ_WIPER);
  assign is_store = (exec_cmd == CMD_STORE_WIPER)
                    || (exec_cmd == CMD_STORE_DATA);
  assign is_report = is_read || (exec_cmd == CMD_RESET_NV);
  assign store_we = (state_reg == ST_STORE)
                    && (store_cnt_reg == 20'h0_0000);
  assign store_wiper = store_reg[`NVW_ADDR_WIPER][9:0];
  assign read_data = (exec_cmd == CMD_READ_WIPER) ?
                     {6'h00, wiper_reg} : store_reg[exec_addr]; // see R14

  // Wiper next value; preset pin outranks everything
  always_comb begin
    wiper_next = wiper_reg;
    if (!preset_lvl) begin
      wiper_next = `NVW_WIPER_MID; // see R17
    end else if (state_reg == ST_POWER_UP) begin
      wiper_next = store_wiper; // see R11
    end else if (preset_rise) begin
      wiper_next = store_wiper; // see R3
    end else if (exec_ok) begin
      case (exec_cmd) // see R13
        CMD_RESTORE, CMD_RESET_NV: begin
          wiper_next = store_wiper; // see R4
        end
        CMD_DEC_6DB, CMD_DEC_6DB_ALL: begin
          wiper_next = {1'b0, wiper_reg[9:1]};
        end
        CMD_DEC_STEP, CMD_DEC_STEP_ALL: begin
          if (wiper_reg != `NVW_WIPER_ZERO) begin
            wiper_next = wiper_reg - 10'h001; // see R19
          end
        end
        CMD_INC_6DB, CMD_INC_6DB_ALL: begin
          wiper_next = wiper_reg[9] ? `NVW_WIPER_MAX
                       : {wiper_reg[8:0], 1'b0}; // see R19
        end
        CMD_INC_STEP, CMD_INC_STEP_ALL: begin
          if (wiper_reg != `NVW_WIPER_MAX) begin
            wiper_next = wiper_reg + 10'h001; // see R19
          end
        end
        CMD_WRITE_WIPER: begin
          if (exec_addr == `NVW_ADDR_WIPER) begin
            wiper_next = exec_data[9:0]; // see R12 see R16
          end
        end
        default: begin
          wiper_next = wiper_reg;
        end
      endcase
    end
  end

  // Control state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_POWER_UP: begin
        state_next = ST_REPORT;
      end
      ST_IDLE: begin
        if (exec_ok && is_store) begin
          state_next = ST_STORE; // see R16
        end else if (preset_rise || (exec_valid && is_report)) begin
          state_next = ST_REPORT; // see R6
        end
      end
      ST_STORE: begin
        if (store_we) begin
          state_next = ST_IDLE; // see R9
        end
      end
      ST_REPORT: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_POWER_UP;
      wiper_reg <= `NVW_WIPER_MID;
    end else begin
      state_reg <= state_next;
      wiper_reg <= wiper_next;
    end
  end

  // Store countdown; data latched when the store starts
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      store_cnt_reg <= 20'h0_0000;
      pend_addr_reg <= `NVW_ADDR_WIPER;
      pend_data_reg <= 16'h0000;
    end else if (state_reg == ST_IDLE && exec_ok && is_store) begin
      store_cnt_reg <= STORE_LOAD; // see R8
      if (exec_cmd == CMD_STORE_DATA
          && exec_addr != `NVW_ADDR_WIPER) begin
        pend_addr_reg <= exec_addr;
        pend_data_reg <= exec_data;
      end else begin
        pend_addr_reg <= `NVW_ADDR_WIPER;
        pend_data_reg <= {6'h00, wiper_reg};
      end
    end else if (state_reg == ST_STORE && !store_we) begin
      store_cnt_reg <= store_cnt_reg - 20'h0_0001;
    end
  end

  // Nonvolatile store; kept across system reset
  genvar e;
  generate
    for (e = 0; e < `NVW_STORE_DEPTH; e++) begin : g_store
      always_ff @(posedge clk_sys_in or negedge factory_reset_n_in) begin
        if (!factory_reset_n_in) begin
          store_reg[e] <= (e == 0) ? `NVW_STORE_WIPER_INIT
                          : `NVW_STORE_USER_INIT; // see R4
        end else if (store_we && pend_addr_reg == 4'(e)) begin
          store_reg[e] <= pend_data_reg;
        end
      end
    end
  endgenerate

  // Serial shift register, frame counter and repeat memory
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_reg <= 24'h00_0000;
      bit_cnt_reg <= 5'h00;
      any_bits_reg <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_reg <= 5'h00;
      any_bits_reg <= 1'b0;
    end else if (exec_valid && is_read) begin
      shift_reg <= {exec_word[23:16], read_data}; // see R14
    end else if (sclk_rise && shifting) begin
      shift_reg <= {shift_reg[22:0], sdi_lvl}; // see R15
      bit_cnt_reg <= (bit_cnt_reg == `NVW_FRAME_LAST) ? 5'h00
                     : bit_cnt_reg + 5'h01;
      any_bits_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_word_reg <= 24'h00_0000;
      prev_valid_reg <= 1'b0;
    end else if (exec_valid && frame_ok) begin
      prev_word_reg <= shift_reg; // see R18
      prev_valid_reg <= 1'b1;
    end
  end

  // Outputs
  assign wiper_scratchpad_out = wiper_reg; // see R10
  assign nv_general_output_one_out =
    store_reg[`NVW_ADDR_OUTPUTS][`NVW_OUT_ONE_BIT];
  assign nv_general_output_two_out =
    store_reg[`NVW_ADDR_OUTPUTS][`NVW_OUT_TWO_BIT]; // see R7
  assign sdo_out = 1'b0;
  assign sdo_oe_out = ~cs_lvl && ~shift_reg[23];
  assign ready_out = 1'b0;
  assign ready_oe_out = (state_reg != ST_IDLE); // see R6 see R9

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in || !factory_reset_n_in);

  sequence s_store_start;
    state_reg == ST_IDLE && exec_ok && is_store;
  endsequence
  sequence s_locked;
    state_reg == ST_STORE && !exec_valid && ready_oe_out;
  endsequence

  property p_wp_blocks;
    exec_valid && wp_block && preset_lvl && !preset_rise
      |=> $stable(wiper_reg) && state_reg != ST_STORE;
  endproperty
  a_wp_blocks: assert property (p_wp_blocks) // see R1
    else $error("write protect let a change through");

  property p_preset_load;
    preset_rise |=> wiper_reg == $past(store_wiper);
  endproperty
  a_preset_load: assert property (p_preset_load) // see R3
    else $error("preset edge did not reload the wiper");

  property p_preset_mid;
    !preset_lvl |=> wiper_reg == `NVW_WIPER_MID;
  endproperty
  a_preset_mid: assert property (p_preset_mid) // see R17
    else $error("preset low did not force midscale");

  property p_restore;
    exec_valid && preset_lvl && !preset_rise
      && (exec_cmd == CMD_RESTORE || exec_cmd == CMD_RESET_NV)
      |=> wiper_reg == $past(store_wiper);
  endproperty
  a_restore: assert property (p_restore) // see R4
    else $error("restore did not load the stored value");

  property p_exec_on_cs;
    exec_valid |-> cs_rise && state_reg == ST_IDLE;
  endproperty
  a_exec_on_cs: assert property (p_exec_on_cs) // see R5
    else $error("command executed without chip select rising");

  property p_ready_cmd;
    exec_valid && (is_report || (is_store && !wp_block))
      |=> ready_oe_out;
  endproperty
  a_ready_cmd: assert property (p_ready_cmd) // see R6
    else $error("ready not pulled low for a reporting command");

  property p_store_lock;
    s_store_start |=> s_locked [*8];
  endproperty
  a_store_lock: assert property (p_store_lock) // see R8
    else $error("store did not lock the shift register");

  property p_store_done;
    store_we |-> ready_oe_out ##1 !ready_oe_out;
  endproperty
  a_store_done: assert property (p_store_done) // see R9
    else $error("ready did not return high after the store");

  property p_write;
    exec_ok && exec_cmd == CMD_WRITE_WIPER && exec_addr == 4'h0
      && preset_lvl && !preset_rise
      |=> wiper_reg == $past(exec_data[9:0]);
  endproperty
  a_write: assert property (p_write) // see R12
    else $error("write command did not set the wiper");

  property p_saturate;
    exec_ok && preset_lvl && !preset_rise
      && exec_cmd == CMD_INC_STEP && wiper_reg == `NVW_WIPER_MAX
      |=> wiper_reg == `NVW_WIPER_MAX;
  endproperty
  a_saturate: assert property (p_saturate) // see R19
    else $error("increment wrapped past full scale");

  property p_repeat;
    state_reg == ST_IDLE && cs_rise && !any_bits_reg && prev_valid_reg
      |-> exec_valid && exec_word == prev_word_reg;
  endproperty
  a_repeat: assert property (p_repeat) // see R18
    else $error("bare chip select pulse did not repeat");

  property p_readback;
    exec_valid && exec_cmd == CMD_READ_WIPER
      |=> shift_reg[15:0] == {6'h00, $past(wiper_reg)};
  endproperty
  a_readback: assert property (p_readback) // see R14
    else $error("readback did not load the wiper value");

  property p_out_two;
    store_we && pend_addr_reg == `NVW_ADDR_OUTPUTS
      |=> nv_general_output_two_out == $past(pend_data_reg[1]);
  endproperty
  a_out_two: assert property (p_out_two) // see R7
    else $error("general output two did not follow its bit");

endmodule

// >>> pkg/nvw_regs.svh
// Frame layout, store map, reset values and timing counts of the
// wiper command block. Included by the core; definitions only.
`ifndef NVW_REGS_SVH
`define NVW_REGS_SVH

// Serial frame: command, address and data fields, MSB first
`define NVW_FRAME_BITS 24
`define NVW_FRAME_LAST 5'h17
`define NVW_CMD_MSB 23
`define NVW_CMD_LSB 20
`define NVW_ADDR_MSB 19
`define NVW_ADDR_LSB 16
`define NVW_DATA_MSB 15
`define NVW_DATA_LSB 0

// Wiper range
`define NVW_WIPER_BITS 10
`define NVW_WIPER_MID 10'h200
`define NVW_WIPER_MAX 10'h3FF
`define NVW_WIPER_ZERO 10'h000

// Nonvolatile store map and factory contents
`define NVW_STORE_DEPTH 16
`define NVW_ADDR_WIPER 4'h0
`define NVW_ADDR_OUTPUTS 4'h1
`define NVW_OUT_ONE_BIT 0
`define NVW_OUT_TWO_BIT 1
`define NVW_STORE_WIPER_INIT 16'h0200
`define NVW_STORE_USER_INIT 16'h0000

// Store timing
`define NVW_CLK_HZ 20000000
`define NVW_STORE_TIME_MS 25
`define NVW_STORE_CYCLES (`NVW_STORE_TIME_MS * (`NVW_CLK_HZ / 1000))

`endif

// >>> pkg/nvw_pkg.sv
// Types of the wiper command block: command codes and control states.
// Assumes nothing of its surroundings.
package nvw_pkg;

  typedef enum logic [3:0] {
    CMD_NOP          = 4'h0,
    CMD_RESTORE      = 4'h1,
    CMD_STORE_WIPER  = 4'h2,
    CMD_STORE_DATA   = 4'h3,
    CMD_DEC_6DB      = 4'h4,
    CMD_DEC_6DB_ALL  = 4'h5,
    CMD_DEC_STEP     = 4'h6,
    CMD_DEC_STEP_ALL = 4'h7,
    CMD_RESET_NV     = 4'h8,
    CMD_READ_NV      = 4'h9,
    CMD_READ_WIPER   = 4'hA,
    CMD_WRITE_WIPER  = 4'hB,
    CMD_INC_6DB      = 4'hC,
    CMD_INC_6DB_ALL  = 4'hD,
    CMD_INC_STEP     = 4'hE,
    CMD_INC_STEP_ALL = 4'hF
  } nvw_cmd_t;

  typedef enum logic [3:0] {
    ST_POWER_UP = 4'h1,
    ST_IDLE     = 4'h2,
    ST_STORE    = 4'h4,
    ST_REPORT   = 4'h8
  } nvw_state_t;

endpackage

// >>> hdl/nvw_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pin inputs and one system clock.
module nvw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic [2:0] stage_reg;
      logic level_reg;
      // Level moves only once stages two and three agree
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          stage_reg <= {3{RESET_VALUE[i]}};
          level_reg <= RESET_VALUE[i];
        end else begin
          stage_reg <= {stage_reg[1:0], async_in[i]};
          if (stage_reg[1] == stage_reg[2]) begin
            level_reg <= stage_reg[2];
          end
        end
      end
      assign level_out[i] = level_reg;
    end
  endgenerate

endmodule

// >>> testbench/nvw_host.sv
// Serial host model: drives chip select, clock and data of the wiper
// block and collects what the block returns on its open-drain data pin.
// Assumes the block samples pins on clk_sys_in and needs >= 4 clk levels.
module nvw_host (
  // System clock for pacing
  input wire logic clk_sys_in,
  // Data returned by the block
  input wire logic sdo_oe_in,
  // Serial pins
  output logic sclk_out,
  output logic sdi_out,
  output logic cs_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [23:0] rx_reg;

  initial begin
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    cs_n_out = 1'b1;
    rx_reg = 24'h00_0000;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // One 24-bit frame, MSB first; SDO pin has a pull-up
  task automatic shift(input logic [23:0] frame);
    cs_n_out = 1'b0;
    hold(5);
    for (int i = 23; i >= 0; i--) begin
      sdi_out = frame[i];
      hold(5);
      rx_reg = {rx_reg[22:0], ~sdo_oe_in};
      sclk_out = 1'b1;
      hold(5);
      sclk_out = 1'b0;
    end
    hold(5);
    // Released line no longer shows the last bit
    sdi_out = ~sdi_out;
  endtask

  task automatic raise_cs();
    cs_n_out = 1'b1;
    hold(10);
  endtask

  task automatic send(input logic [23:0] frame);
    shift(frame);
    raise_cs();
  endtask

  // Chip select strobe with no clock edges
  task automatic pulse_cs();
    cs_n_out = 1'b0;
    hold(5);
    raise_cs();
  endtask
endmodule

// >>> testbench/nvw_core_tb.sv
// Self-checking bench of the wiper command block with a serial host.
// Assumes a 20 MHz system clock and a shortened store time.
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module nvw_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvw_pkg::*;

  localparam int STORE_CYCLES = 600;

  logic clk_sys_in, reset_n_in, factory_reset_n_in;
  logic sclk, sdi, cs_n, write_protect_n_in, preset_strobe_n_in;
  logic sdo_out, sdo_oe_out, ready_out, ready_oe_out;
  logic [9:0] wiper_scratchpad_out;
  logic out_one, out_two;
  int errors, n_tests;
  logic [24:0] ops [19];
  logic [9:0] exp_w [19];

  nvw_core #(.STORE_CYCLES(STORE_CYCLES)) i_dut (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .factory_reset_n_in(factory_reset_n_in),
    .sclk_in(sclk),
    .sdi_in(sdi),
    .cs_n_in(cs_n),
    .sdo_out(sdo_out),
    .sdo_oe_out(sdo_oe_out),
    .write_protect_n_in(write_protect_n_in),
    .preset_strobe_n_in(preset_strobe_n_in),
    .ready_out(ready_out),
    .ready_oe_out(ready_oe_out),
    .wiper_scratchpad_out(wiper_scratchpad_out),
    .nv_general_output_one_out(out_one),
    .nv_general_output_two_out(out_two)
  );

  nvw_host i_host (
    .clk_sys_in(clk_sys_in),
    .sdo_oe_in(sdo_oe_out),
    .sclk_out(sclk),
    .sdi_out(sdi),
    .cs_n_out(cs_n)
  );

  always #25 clk_sys_in = ~clk_sys_in;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_oe_out !== 1'b0 && n < 2000) begin
      i_host.hold(1);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      $display("[FAIL] %0t ready never returned", $time);
      wrap_up();
    end
  endtask

  task automatic put(input logic [23:0] frame);
    i_host.send(frame);
    wait_ready();
  endtask

  initial begin
    // Bit 24 marks a bare chip select strobe
    ops = '{25'h0B0_0000, 25'h060_0000, 25'h070_0000, 25'h0E0_0000,
            25'h100_0000, 25'h0F0_0000, 25'h0C0_0000, 25'h0D0_0000,
            25'h050_0000, 25'h040_0000, 25'h0B0_03FF, 25'h0E0_0000,
            25'h0C0_0000, 25'h040_0000, 25'h000_0000, 25'h0B1_0123,
            25'h010_0000, 25'h0B0_0080, 25'h080_0000};
    exp_w = '{10'h000, 10'h000, 10'h000, 10'h001, 10'h002, 10'h003,
              10'h006, 10'h00C, 10'h006, 10'h003, 10'h3FF, 10'h3FF,
              10'h3FF, 10'h1FF, 10'h1FF, 10'h1FF, 10'h100, 10'h080,
              10'h100};
    clk_sys_in = 1'b0;
    reset_n_in = 1'b0;
    factory_reset_n_in = 1'b0;
    write_protect_n_in = 1'b1;
    preset_strobe_n_in = 1'b1;
    errors = 0;
    n_tests = 0;
    i_host.hold(3);
    reset_n_in = 1'b1;
    factory_reset_n_in = 1'b1;
    wait_ready();
    `CHK(wiper_scratchpad_out, 10'h200)
    i_host.shift(24'hB0_0100);
    `CHK(wiper_scratchpad_out, 10'h200)
    i_host.raise_cs();
    `CHK(wiper_scratchpad_out, 10'h100)
    // Store, with a write attempted while the store runs
    i_host.send(24'h20_0000);
    `CHK(ready_oe_out, 1'b1)
    i_host.send(24'hB0_0055);
    `CHK(ready_oe_out, 1'b1)
    wait_ready();
    `CHK(wiper_scratchpad_out, 10'h100)
    for (int i = 0; i < 19; i++) begin
      if (ops[i][24]) begin
        i_host.pulse_cs();
        wait_ready();
      end else begin
        put(ops[i][23:0]);
      end
      `CHK(wiper_scratchpad_out, exp_w[i])
    end
    // Readback of wiper and of the store in the following frame
    put(24'hB0_0155);
    put(24'hA0_0000);
    put(24'h00_0000);
    `CHK(i_host.rx_reg, 24'hA0_0155)
    put(24'h90_0000);
    put(24'h00_0000);
    `CHK(i_host.rx_reg, 24'h90_0100)
    preset_strobe_n_in = 1'b0;
    i_host.hold(10);
    `CHK(wiper_scratchpad_out, 10'h200)
    preset_strobe_n_in = 1'b1;
    i_host.hold(10);
    `CHK(wiper_scratchpad_out, 10'h100)
    wait_ready();
    // Write protection: writes refused, restore still allowed
    put(24'hB0_0155);
    write_protect_n_in = 1'b0;
    i_host.hold(10);
    put(24'hB0_0033);
    `CHK(wiper_scratchpad_out, 10'h155)
    put(24'h60_0000);
    `CHK(wiper_scratchpad_out, 10'h155)
    put(24'h80_0000);
    `CHK(wiper_scratchpad_out, 10'h100)
    put(24'h00_0000);
    write_protect_n_in = 1'b1;
    i_host.hold(10);
    put(24'h31_0002);
    `CHK(out_two, 1'b1)
    `CHK(out_one, 1'b0)
    put(24'hB0_0000);
    `CHK(wiper_scratchpad_out, 10'h000)
    // Power cycle keeps the saved position
    reset_n_in = 1'b0;
    i_host.hold(3);
    reset_n_in = 1'b1;
    wait_ready();
    `CHK(wiper_scratchpad_out, 10'h100)
    `CHK(sdo_out, 1'b0)
    `CHK(ready_out, 1'b0)
    // Factory state again, then power cycle: midscale comes back
    factory_reset_n_in = 1'b0;
    i_host.hold(3);
    factory_reset_n_in = 1'b1;
    reset_n_in = 1'b0;
    i_host.hold(3);
    reset_n_in = 1'b1;
    wait_ready();
    `CHK(wiper_scratchpad_out, 10'h200)
    `CHK(out_two, 1'b0)
    wrap_up();
  end
endmodule
